/* design/axsbe_encoder.v */
// address-channel stage that attaches user sideband bits on six channels
//
// Implementation choices: the Avalon-MM slave port and the address map.
`include "axsbe_consts.vh"

module axsbe_encoder
#(
   parameter AW = 32
)
(
   input  wire                       mclk,
   input  wire                       nrst,
   // avalon-mm register slave
   input  wire [3:0]                 avs_address,
   input  wire                       avs_read,
   input  wire                       avs_write,
   input  wire [31:0]                avs_writedata,
   input  wire [3:0]                 avs_byteenable,
   output reg  [31:0]                avs_readdata,
   output wire                       avs_waitrequest,
   // request side, one bit or slice per channel; req_spec only for the two master read channels
   input  wire [`AXSBE_NCH-1:0]      req_valid,
   output wire [`AXSBE_NCH-1:0]      req_ready,
   input  wire [`AXSBE_NCH*AW-1:0]   req_addr,
   input  wire [`AXSBE_NCH*2-1:0]    req_src,
   input  wire [`AXSBE_NCH*3-1:0]    req_mtype,
   input  wire [`AXSBE_NCH-1:0]      req_share,
   input  wire [1:0]                 req_spec,
   // master 0 read address
   output wire                       m0_arvalid,
   input  wire                       m0_arready,
   output wire [AW-1:0]              m0_araddr,
   output wire [`AXSBE_RD_W-1:0]     master0_read_sideband,
   // master 1 read address
   output wire                       m1_arvalid,
   input  wire                       m1_arready,
   output wire [AW-1:0]              m1_araddr,
   output wire [`AXSBE_RD_W-1:0]     master1_read_sideband,
   // peripheral read address
   output wire                       mp_arvalid,
   input  wire                       mp_arready,
   output wire [AW-1:0]              mp_araddr,
   output wire [`AXSBE_RD_W-1:0]     periph_read_sideband,
   // master 0 write address
   output wire                       m0_awvalid,
   input  wire                       m0_awready,
   output wire [AW-1:0]              m0_awaddr,
   output wire [`AXSBE_WR_W-1:0]     master0_write_sideband,
   // master 1 write address
   output wire                       m1_awvalid,
   input  wire                       m1_awready,
   output wire [AW-1:0]              m1_awaddr,
   output wire [`AXSBE_WR_W-1:0]     master1_write_sideband,
   // peripheral write address
   output wire                       mp_awvalid,
   input  wire                       mp_awready,
   output wire [AW-1:0]              mp_awaddr,
   output wire [`AXSBE_WR_W-1:0]     periph_write_sideband
);

   localparam NCH = `AXSBE_NCH;
   localparam CH_M0_RD = 0;
   localparam CH_M1_RD = 1;
   localparam CH_MP_RD = 2;
   localparam CH_M0_WR = 3;
   localparam CH_M1_WR = 4;
   localparam CH_MP_WR = 5;

   // ****************************************************************
   // sideband layout functions
   // ****************************************************************
   function [`AXSBE_RD_W-1:0] rd_layout;
      input [1:0] orig;
      input       spec;
      input [3:0] inner;
      input       share;
      begin
         rd_layout = {`AXSBE_RD_W{1'h0}};
         rd_layout[`AXSBE_RD_ORIG_HI:`AXSBE_RD_ORIG_LO] = orig;
         rd_layout[`AXSBE_RD_SPEC] = spec;
         rd_layout[`AXSBE_IA_HI:`AXSBE_IA_LO] = inner;
         rd_layout[`AXSBE_SHARE] = share;
      end
   endfunction

   function [`AXSBE_WR_W-1:0] wr_layout;
      input [1:0] orig;
      input       early;
      input [3:0] inner;
      input       share;
      begin
         wr_layout = {`AXSBE_WR_W{1'h0}};
         wr_layout[`AXSBE_WR_ORIG_HI:`AXSBE_WR_ORIG_LO] = orig;
         wr_layout[`AXSBE_WR_EARLY] = early;
         wr_layout[`AXSBE_IA_HI:`AXSBE_IA_LO] = inner;
         wr_layout[`AXSBE_SHARE] = share;
      end
   endfunction

   // ****************************************************************
   // per-channel attribute encoders
   // ****************************************************************
   wire [NCH*2-1:0] enc_orig;
   wire [NCH*4-1:0] enc_inner;
   wire [NCH-1:0]   enc_bad;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1)
      begin : g_enc
         axsbe_attr_enc u_enc
         (
            .src   (req_src[g*2 +: 2]),
            .mtype (req_mtype[g*3 +: 3]),
            .orig  (enc_orig[g*2 +: 2]),
            .inner (enc_inner[g*4 +: 4]),
            .bad   (enc_bad[g])
         );
      end
   endgenerate

   // ****************************************************************
   // control register
   // ****************************************************************
   reg  [1:0] ctrl_q;
   wire       early_en;
   wire       spec_en;

   assign early_en = ctrl_q[`AXSBE_CTRL_EARLY];
   assign spec_en  = ctrl_q[`AXSBE_CTRL_SPEC];

   // ****************************************************************
   // address-channel holding stage
   // ****************************************************************
   // one entry per channel; a new request is taken only when the entry
   // is empty or leaving, so the payload never moves under valid
   reg [NCH-1:0] vld_q;
   reg [AW-1:0]  addr_q  [0:NCH-1];
   reg [1:0]     orig_q  [0:NCH-1];
   reg [3:0]     inner_q [0:NCH-1];
   reg [NCH-1:0] share_q;
   reg [NCH-1:0] spec_q;
   reg [NCH-1:0] early_q;

   wire [NCH-1:0] axi_ready;
   wire [NCH-1:0] accept;
   wire [NCH-1:0] spec_d;
   wire [NCH-1:0] early_d;

   assign axi_ready = {mp_awready, m1_awready, m0_awready,
                       mp_arready, m1_arready, m0_arready};

   assign req_ready = ~vld_q | axi_ready;
   assign accept    = req_valid & req_ready;

   // both are captured at acceptance, so a ctrl write never alters a
   // request that is already standing on its address channel
   // hint only on the two master read channels, offer only on master writes
   assign spec_d  = {4'h0, req_spec & {2{spec_en}}};
   assign early_d = {1'h0, {2{early_en}}, 3'h0};

   // the counter sum has its own index so that no loop variable is
   // written from both the clocked and the combinational process
   integer i;
   integer j;

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         vld_q   <= {NCH{1'h0}};
         share_q <= {NCH{1'h0}};
         spec_q  <= {NCH{1'h0}};
         early_q <= {NCH{1'h0}};
         for (i = 0; i < NCH; i = i + 1)
         begin
            addr_q[i]  <= {AW{1'h0}};
            orig_q[i]  <= 2'h0;
            inner_q[i] <= 4'h0;
         end
      end
      else
      begin
         for (i = 0; i < NCH; i = i + 1)
         begin
            if (accept[i])
            begin
               vld_q[i]   <= 1'h1;
               addr_q[i]  <= req_addr[i*AW +: AW];
               orig_q[i]  <= enc_orig[i*2 +: 2];
               inner_q[i] <= enc_inner[i*4 +: 4];
               share_q[i] <= req_share[i];
               spec_q[i]  <= spec_d[i];
               early_q[i] <= early_d[i];
            end
            else if (axi_ready[i])
            begin
               vld_q[i] <= 1'h0;
            end
         end
      end
   end

   // ****************************************************************
   // address channel outputs
   // ****************************************************************
   assign m0_arvalid = vld_q[CH_M0_RD];
   assign m1_arvalid = vld_q[CH_M1_RD];
   assign mp_arvalid = vld_q[CH_MP_RD];
   assign m0_awvalid = vld_q[CH_M0_WR];
   assign m1_awvalid = vld_q[CH_M1_WR];
   assign mp_awvalid = vld_q[CH_MP_WR];

   assign m0_araddr = addr_q[CH_M0_RD];
   assign m1_araddr = addr_q[CH_M1_RD];
   assign mp_araddr = addr_q[CH_MP_RD];
   assign m0_awaddr = addr_q[CH_M0_WR];
   assign m1_awaddr = addr_q[CH_M1_WR];
   assign mp_awaddr = addr_q[CH_MP_WR];

   // reserved bits come out of the layout functions as zero
   assign master0_read_sideband = rd_layout(orig_q[CH_M0_RD],
      spec_q[CH_M0_RD], inner_q[CH_M0_RD], share_q[CH_M0_RD]);
   assign master1_read_sideband = rd_layout(orig_q[CH_M1_RD],
      spec_q[CH_M1_RD], inner_q[CH_M1_RD], share_q[CH_M1_RD]);
   assign periph_read_sideband = rd_layout(orig_q[CH_MP_RD],
      1'h0, inner_q[CH_MP_RD], share_q[CH_MP_RD]);
   assign master0_write_sideband = wr_layout(orig_q[CH_M0_WR],
      early_q[CH_M0_WR], inner_q[CH_M0_WR], share_q[CH_M0_WR]);
   assign master1_write_sideband = wr_layout(orig_q[CH_M1_WR],
      early_q[CH_M1_WR], inner_q[CH_M1_WR], share_q[CH_M1_WR]);
   assign periph_write_sideband = wr_layout(orig_q[CH_MP_WR],
      1'h0, inner_q[CH_MP_WR], share_q[CH_MP_WR]);

   // ****************************************************************
   // reserved-code counter
   // ****************************************************************
   // counts accepted requests whose source or type had no encoding
   reg  [`AXSBE_ERRCNT_W-1:0] errcnt_q;
   reg  [`AXSBE_ERRCNT_W-1:0] errcnt_d;
   reg  [3:0]                 nbad;
   wire [NCH-1:0]             bad_acc;
   wire                       errcnt_clr;

   assign bad_acc = accept & enc_bad;

   always @*
   begin
      nbad = 4'h0;
      for (j = 0; j < NCH; j = j + 1)
      begin
         nbad = nbad + {3'h0, bad_acc[j]};
      end
   end

   // a clear that meets new events keeps the new events
   always @*
   begin
      if (errcnt_clr)
      begin
         errcnt_d = {{(`AXSBE_ERRCNT_W-4){1'h0}}, nbad};
      end
      else if (errcnt_q > ({`AXSBE_ERRCNT_W{1'h1}} -
                           {{(`AXSBE_ERRCNT_W-4){1'h0}}, nbad}))
      begin
         errcnt_d = {`AXSBE_ERRCNT_W{1'h1}};
      end
      else
      begin
         errcnt_d = errcnt_q + {{(`AXSBE_ERRCNT_W-4){1'h0}}, nbad};
      end
   end

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         errcnt_q <= {`AXSBE_ERRCNT_W{1'h0}};
      end
      else
      begin
         errcnt_q <= errcnt_d;
      end
   end

   // ****************************************************************
   // avalon-mm slave
   // ****************************************************************
   // every access takes exactly one wait cycle; readdata is loaded in
   // the wait cycle and stands at the edge where waitrequest is low
   // ack_q falls on the completion edge, so a request raised right
   // after it sees its own wait cycle again
   reg  ack_q;
   wire acc;
   wire wr_go;

   assign acc             = avs_read | avs_write;
   assign avs_waitrequest = acc & ~ack_q;
   assign wr_go           = avs_write & ack_q;
   assign errcnt_clr      = wr_go & (avs_address == `AXSBE_OFF_ERRCNT);

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_q <= 1'h0;
      end
      else
      begin
         ack_q <= acc & ~ack_q;
      end
   end

   // offer and hint are on from reset, software may turn either off or back on
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q <= `AXSBE_CTRL_RESET;
      end
      else if (wr_go && avs_address == `AXSBE_OFF_CTRL &&
               avs_byteenable[0])
      begin
         ctrl_q <= avs_writedata[1:0];
      end
   end

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         avs_readdata <= 32'h0;
      end
      else if (avs_read && !ack_q)
      begin
         case (avs_address)
            `AXSBE_OFF_CTRL:   avs_readdata <= {30'h0, ctrl_q};
            `AXSBE_OFF_STATUS: avs_readdata <= {26'h0, vld_q};
            `AXSBE_OFF_ERRCNT: avs_readdata <= {16'h0, errcnt_q};
            default:           avs_readdata <= 32'h0;
         endcase
      end
   end

endmodule

/* design/axsbe_consts.vh */
// constants for the address-channel user sideband encoder
`ifndef AXSBE_CONSTS_VH
`define AXSBE_CONSTS_VH

// ****************************************************************
// register map (byte offsets on the avalon slave)
// ****************************************************************
`define AXSBE_OFF_CTRL      4'h0
`define AXSBE_OFF_STATUS    4'h4
`define AXSBE_OFF_ERRCNT    4'h8
`define AXSBE_CTRL_EARLY    0
`define AXSBE_CTRL_SPEC     1
`define AXSBE_CTRL_RESET    2'h3
`define AXSBE_ERRCNT_W      16

// ****************************************************************
// request-side source and memory type codes
// ****************************************************************
`define AXSBE_SRC_CPU0      2'h0
`define AXSBE_SRC_CPU1      2'h1
`define AXSBE_SRC_COH       2'h2
`define AXSBE_MT_SO         3'h0
`define AXSBE_MT_DEV        3'h1
`define AXSBE_MT_NC         3'h2
`define AXSBE_MT_WT         3'h3
`define AXSBE_MT_WB_NWA     3'h4
`define AXSBE_MT_WB_WA      3'h5

// ****************************************************************
// sideband encodings
// ****************************************************************
`define AXSBE_ORIG_CPU0     2'h0
`define AXSBE_ORIG_CPU1     2'h2
`define AXSBE_ORIG_COH      2'h1
`define AXSBE_IA_SO         4'h0
`define AXSBE_IA_DEV        4'h1
`define AXSBE_IA_NC         4'h3
`define AXSBE_IA_WT         4'h6
`define AXSBE_IA_WB_NWA     4'h7
`define AXSBE_IA_WB_WA      4'hF

// ****************************************************************
// sideband field positions
// ****************************************************************
`define AXSBE_RD_W          9
`define AXSBE_WR_W          11
`define AXSBE_RD_ORIG_HI    8
`define AXSBE_RD_ORIG_LO    7
`define AXSBE_RD_SPEC       6
`define AXSBE_WR_ORIG_HI    10
`define AXSBE_WR_ORIG_LO    9
`define AXSBE_WR_EARLY      8
`define AXSBE_IA_HI         4
`define AXSBE_IA_LO         1
`define AXSBE_SHARE         0

// channel indices: 0..2 reads of m0, m1, periph; 3..5 writes
`define AXSBE_NCH           6

`endif

/* design/axsbe_attr_enc.v */
// originator and inner attribute encoding for one address channel
`include "axsbe_consts.vh"

module axsbe_attr_enc
(
   input  wire [1:0] src,
   input  wire [2:0] mtype,
   output reg  [1:0] orig,
   output reg  [3:0] inner,
   output wire       bad
);

   reg bad_src;
   reg bad_mt;

   // reserved originator 11 can never be produced here
   always @*
   begin
      bad_src = 1'h0;
      case (src)
         `AXSBE_SRC_CPU0: orig = `AXSBE_ORIG_CPU0;
         `AXSBE_SRC_CPU1: orig = `AXSBE_ORIG_CPU1;
         `AXSBE_SRC_COH:  orig = `AXSBE_ORIG_COH;
         default:
         begin
            orig    = `AXSBE_ORIG_CPU0;
            bad_src = 1'h1;
         end
      endcase
   end

   // unknown types fall back to the safest ordering, strongly ordered
   always @*
   begin
      bad_mt = 1'h0;
      case (mtype)
         `AXSBE_MT_SO:     inner = `AXSBE_IA_SO;
         `AXSBE_MT_DEV:    inner = `AXSBE_IA_DEV;
         `AXSBE_MT_NC:     inner = `AXSBE_IA_NC;
         `AXSBE_MT_WT:     inner = `AXSBE_IA_WT;
         `AXSBE_MT_WB_NWA: inner = `AXSBE_IA_WB_NWA;
         `AXSBE_MT_WB_WA:  inner = `AXSBE_IA_WB_WA;
         default:
         begin
            inner  = `AXSBE_IA_SO;
            bad_mt = 1'h1;
         end
      endcase
   end

   assign bad = bad_src | bad_mt;

endmodule

/* verif/axsbe_monitor.sv */
// concurrent checks on the sideband encoder ports
`include "axsbe_consts.vh"
module axsbe_monitor
(
   input wire logic                      mclk,
   input wire logic                      nrst,
   input wire logic [`AXSBE_NCH-1:0]     req_valid,
   input wire logic [`AXSBE_NCH-1:0]     req_ready,
   input wire logic [`AXSBE_NCH*2-1:0]   req_src,
   input wire logic [`AXSBE_NCH*3-1:0]   req_mtype,
   input wire logic [`AXSBE_NCH-1:0]     req_share,
   input wire logic                      m1_arvalid,
   input wire logic                      m1_arready,
   input wire logic                      m0_awvalid,
   input wire logic                      m1_awvalid,
   input wire logic                      m1_awready,
   input wire logic [`AXSBE_RD_W-1:0]    master0_read_sideband,
   input wire logic [`AXSBE_RD_W-1:0]    master1_read_sideband,
   input wire logic [`AXSBE_RD_W-1:0]    periph_read_sideband,
   input wire logic [`AXSBE_WR_W-1:0]    master0_write_sideband,
   input wire logic [`AXSBE_WR_W-1:0]    master1_write_sideband,
   input wire logic [`AXSBE_WR_W-1:0]    periph_write_sideband
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // reference encodings, illegal codes fall back to zero
   // ****************************************************************
   function automatic logic [1:0] og(input logic [1:0] s);
      return s == 2'h1 ? 2'h2 : s == 2'h2 ? 2'h1 : 2'h0;
   endfunction
   function automatic logic [3:0] ia(input logic [2:0] m);
      return m == 3'h1 ? 4'h1 : m == 3'h2 ? 4'h3 : m == 3'h3 ? 4'h6 :
             m == 3'h4 ? 4'h7 : m == 3'h5 ? 4'hF : 4'h0;
   endfunction

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   chk_prd_resv: assert property (periph_read_sideband[6:5] == 2'h0)
      else $error("periph read reserved bits set");
   chk_pwr_resv: assert property (periph_write_sideband[8:5] == 4'h0)
      else $error("periph write reserved bits set");
   chk_m0w_resv: assert property (master0_write_sideband[7:5] == 3'h0)
      else $error("m0 write reserved bits set");
   chk_m1w_resv: assert property (master1_write_sideband[7:5] == 3'h0)
      else $error("m1 write reserved bits set");
   chk_rd_bit5: assert property (!master0_read_sideband[5] &&
      !master1_read_sideband[5]) else $error("read bit 5 set");
   chk_orig_legal: assert property (
      master1_read_sideband[8:7] != 2'h3 &&
      master0_write_sideband[10:9] != 2'h3 &&
      periph_write_sideband[10:9] != 2'h3) else $error("reserved origin");
   chk_m1r_enc: assert property (
      req_valid[1] && req_ready[1] |=> m1_arvalid
      && master1_read_sideband[8:7] == og($past(req_src[3:2]))
      && master1_read_sideband[4:1] == ia($past(req_mtype[5:3]))
      && master1_read_sideband[0] == $past(req_share[1]))
      else $error("m1 read encoding wrong");
   chk_m0w_enc: assert property (
      req_valid[3] && req_ready[3] |=> m0_awvalid
      && master0_write_sideband[10:9] == og($past(req_src[7:6]))
      && master0_write_sideband[4:1] == ia($past(req_mtype[11:9]))
      && master0_write_sideband[0] == $past(req_share[3]))
      else $error("m0 write encoding wrong");
   chk_m1r_hold: assert property (m1_arvalid && !m1_arready |=>
      m1_arvalid && $stable(master1_read_sideband))
      else $error("m1 read sideband moved while stalled");
   chk_m1w_hold: assert property (m1_awvalid && !m1_awready |=>
      m1_awvalid && $stable(master1_write_sideband))
      else $error("m1 write sideband moved while stalled");

   cover property (m1_arvalid && !m1_arready);
   cover property (req_valid[5] && req_ready[5]);
   cover property (req_valid[3] && req_ready[3] && req_mtype[11:9] == 3'h5);
endmodule

bind axsbe_encoder axsbe_monitor mon_u (.mclk, .nrst, .req_valid,
   .req_ready, .req_src, .req_mtype, .req_share, .m1_arvalid, .m1_arready,
   .m0_awvalid, .m1_awvalid, .m1_awready, .master0_read_sideband,
   .master1_read_sideband, .periph_read_sideband, .master0_write_sideband,
   .master1_write_sideband, .periph_write_sideband);

/* verif/axsbe_slave_model.sv */
// address-channel slave model, prompt or stalling at random
module axsbe_slave_model
(
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic       slow,
   output logic [5:0]     ready
);
   timeunit 1ns;
   timeprecision 1ns;
   integer seed = 60;
   // ready ignores the early offer: answering the normal way is legal
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         ready <= 6'h00;
      else
         ready <= slow ? 6'($random(seed)) : 6'h3F;
   end
endmodule

/* verif/testbench.sv */
// self-checking bench for the address-channel sideband encoder
`include "axsbe_consts.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam AW = 32;
   logic            mclk = 1'h0;
   logic            nrst = 1'h0;
   logic [3:0]      avs_address = 4'h0;
   logic            avs_read = 1'h0;
   logic            avs_write = 1'h0;
   logic [31:0]     avs_writedata = 32'h0;
   logic [3:0]      avs_byteenable = 4'hF;
   wire [31:0]      avs_readdata;
   wire             avs_waitrequest;
   logic [5:0]      req_valid = 6'h00;
   logic [5:0]      req_share = 6'h00;
   logic [6*AW-1:0] req_addr = '0;
   logic [11:0]     req_src = 12'h000;
   logic [17:0]     req_mtype = 18'h00000;
   logic [1:0]      req_spec = 2'h0;
   logic [1:0]      ctrl = 2'h3;
   logic            slow = 1'h0;
   logic            run = 1'h0;
   logic [31:0]     rd;
   wire [5:0]       req_ready;
   wire [5:0]       axv;
   wire [5:0]       rdy;
   wire [AW-1:0]    ad [6];
   wire [8:0]       sbr [3];
   wire [10:0]      sbw [3];
   logic [AW+10:0]  q [6][$];
   integer          seed = 60;
   integer          fails = 0;
   integer          checked = 0;
   integer          errs = 0;
   integer          i;

   always #5 mclk = ~mclk;

   axsbe_encoder #(.AW(AW)) dut_u (.mclk, .nrst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .req_valid, .req_ready, .req_addr, .req_src,
      .req_mtype, .req_share, .req_spec,
      .m0_arvalid(axv[0]), .m0_arready(rdy[0]), .m0_araddr(ad[0]),
      .master0_read_sideband(sbr[0]),
      .m1_arvalid(axv[1]), .m1_arready(rdy[1]), .m1_araddr(ad[1]),
      .master1_read_sideband(sbr[1]),
      .mp_arvalid(axv[2]), .mp_arready(rdy[2]), .mp_araddr(ad[2]),
      .periph_read_sideband(sbr[2]),
      .m0_awvalid(axv[3]), .m0_awready(rdy[3]), .m0_awaddr(ad[3]),
      .master0_write_sideband(sbw[0]),
      .m1_awvalid(axv[4]), .m1_awready(rdy[4]), .m1_awaddr(ad[4]),
      .master1_write_sideband(sbw[1]),
      .mp_awvalid(axv[5]), .mp_awready(rdy[5]), .mp_awaddr(ad[5]),
      .periph_write_sideband(sbw[2]));
   axsbe_slave_model slv_u (.mclk, .nrst, .slow, .ready(rdy));

   task automatic wrap_up;
      if (fails == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [63:0] g, input logic [63:0] e);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // ****************************************************************
   // reference model of one accepted request
   // ****************************************************************
   function automatic logic [10:0] expsb(input int c);
      logic [1:0] s;
      logic [2:0] m;
      logic [3:0] a;
      s = req_src[2*c +: 2];
      m = req_mtype[3*c +: 3];
      a = m == 3'h1 ? 4'h1 : m == 3'h2 ? 4'h3 : m == 3'h3 ? 4'h6 :
          m == 3'h4 ? 4'h7 : m == 3'h5 ? 4'hF : 4'h0;
      s = s == 2'h1 ? 2'h2 : s == 2'h2 ? 2'h1 : 2'h0;
      if (c < 3)
         return {2'h0, s, c < 2 && req_spec[c] && ctrl[1], 1'h0, a,
                 req_share[c]};
      return {s, c < 5 && ctrl[0], 3'h0, a, req_share[c]};
   endfunction

   // avalon request held until waitrequest is sampled low
   task automatic av(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !w;
      avs_write <= w;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      check(n, 2);
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge mclk);
   endtask

   // drained phase: registers, then traffic prompt and stalled
   task automatic phase(input logic [1:0] c);
      run <= 1'h0;
      slow <= 1'h0;
      repeat (20) @(posedge mclk);
      for (int k = 0; k < 6; k++)
         check(q[k].size(), 0);
      av(1'h0, 4'h4, 0, 4'hF);
      check(rd, 0);
      av(1'h0, 4'h8, 0, 4'hF);
      check(rd, errs);
      av(1'h1, 4'h8, 0, 4'hF);
      errs = 0;
      av(1'h1, 4'hC, 32'hFFFFFFFF, 4'hF);
      av(1'h1, 4'h0, {30'h0, ~ctrl}, 4'hE);
      av(1'h0, 4'h0, 0, 4'hF);
      check(rd, ctrl);
      av(1'h0, 4'hC, 0, 4'hF);
      check(rd, 0);
      av(1'h1, 4'h0, {30'h0, c}, 4'h1);
      ctrl = c;
      run <= 1'h1;
      repeat (150) @(posedge mclk);
      slow <= 1'h1;
      repeat (150) @(posedge mclk);
   endtask

   // ****************************************************************
   // drivers of the request side and scoreboard at every handshake
   // ****************************************************************
   always @(posedge mclk)
   begin
      for (i = 0; i < 6; i++)
      begin
         if (axv[i] === 1'h1 && rdy[i] === 1'h1)
            check({ad[i], i < 3 ? {2'h0, sbr[i % 3]} : sbw[i % 3]},
                  q[i].size() ? q[i].pop_front() : '1);
         if (req_valid[i] && req_ready[i] === 1'h1)
         begin
            q[i].push_back({req_addr[i*AW +: AW], expsb(i)});
            if (req_src[2*i +: 2] == 2'h3 || req_mtype[3*i +: 3] > 3'h5)
               errs = errs + 1;
         end
         if (!req_valid[i] || req_ready[i] === 1'h1)
         begin
            req_valid[i] <= run & 1'($random(seed));
            req_addr[i*AW +: AW] <= 32'($random(seed));
            req_src[2*i +: 2] <= 2'($random(seed));
            req_mtype[3*i +: 3] <= 3'($random(seed));
            req_share[i] <= 1'($random(seed));
            if (i < 2)
               req_spec[i] <= 1'($random(seed));
         end
      end
   end

   initial
   begin
      repeat (10) @(posedge mclk);
      nrst <= 1'h1;
      @(posedge mclk);
      phase(2'h3);
      phase(2'h0);
      phase(2'h1);
      phase(2'h2);
      phase(2'h3);
      wrap_up();
   end

   initial
   begin
      #100000;
      fails++;
      wrap_up();
   end
endmodule
